// >>> src/odr_out_cond.sv
// Behaviour
// RQ1 - on delay raises output only after full delay; code counts a free-running tick, so the rise can come up to one tick early
// RQ2 - off delay holds output, bridging short gaps
// RQ3 - both delays shift both edges, short pulses dropped
// RQ4 - nonzero delays accepted from 0.1 to 100 s
// RQ5 - separate on/off delays per output
// RQ6 - delays span 0 to 100 s, reset zero
// RQ7 - delay applies to any assigned function
// RQ8 - relay coil follows polarity setting 00 or 01
// RQ9 - reset: relay alarm function, polarity 01
// RQ10 - any function routable to the relay
// RQ11 - run function asserted while drive runs
// RQ12 - run output active low, pulls pin down
// RQ13 - delay counts tenth-second ticks, reloads on change
// RQ14 - new settings apply without output glitches
`timescale 1ns/1ps
`default_nettype none
module odr_out_cond
  import odr_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [FUNC_NUM-1:0] func_src,
  input wire logic drive_running,
  output logic oc_pin_o,
  output logic oc_pin_oe_n,
  output logic second_pin_o,
  output logic second_pin_oe_n,
  output logic relay_coil
);
  // settings registers
  logic [POL_W-1:0] relay_coil_polarity_reg;
  logic [FUNC_W-1:0] relay_function_select_reg;
  logic [FUNC_W-1:0] oc_function_select_reg;
  logic [FUNC_W-1:0] second_function_select_reg;
  logic [DLY_W-1:0] oc_output_on_delay_reg;
  logic [DLY_W-1:0] oc_output_off_delay_reg;
  logic [DLY_W-1:0] second_output_on_delay_reg;
  logic [DLY_W-1:0] second_output_off_delay_reg;
  logic [DLY_W-1:0] relay_on_delay_reg;
  logic [DLY_W-1:0] relay_off_delay_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [POL_W-1:0] pol_active_reg;
  logic coil_reg;
  logic oc_oe_n_reg;
  logic second_oe_n_reg;

  // picks the source of a function code; run code follows the run state
  function automatic logic func_pick(input logic [FUNC_W-1:0] code,
                                     input logic [FUNC_NUM-1:0] vec,
                                     input logic running);
    func_pick = (code == FUNC_RUN) ? running : vec[code]; // [RQ11]
  endfunction

  // clamps a written delay to the top of the range
  function automatic logic [DLY_W-1:0] dly_clamp(input logic [31:0] val);
    dly_clamp = (val > 32'(DLY_MAX)) ? DLY_MAX : val[DLY_W-1:0]; // [RQ4] [RQ6]
  endfunction

  // apb decode
  wire logic setup = psel && !penable;
  wire logic wr_en = psel && penable && pwrite;
  wire logic hit_pol = (paddr == OFS_RELAY_POL);
  wire logic hit_rfunc = (paddr == OFS_RELAY_FUNC);
  wire logic hit_ofunc = (paddr == OFS_OC_FUNC);
  wire logic hit_sfunc = (paddr == OFS_SECOND_FUNC);
  wire logic hit_oon = (paddr == OFS_OC_ON);
  wire logic hit_ooff = (paddr == OFS_OC_OFF);
  wire logic hit_son = (paddr == OFS_SECOND_ON);
  wire logic hit_soff = (paddr == OFS_SECOND_OFF);
  wire logic hit_ron = (paddr == OFS_RELAY_ON);
  wire logic hit_roff = (paddr == OFS_RELAY_OFF);
  wire logic hit_stat = (paddr == OFS_STATUS);
  wire logic hit_any = hit_pol | hit_rfunc | hit_ofunc | hit_sfunc | hit_oon | hit_ooff
                       | hit_son | hit_soff | hit_ron | hit_roff | hit_stat;

  // function routing through the delay stage
  wire logic tick;
  wire logic [NUM_OUT-1:0] src_vec;
  wire logic [NUM_OUT-1:0] dly_out;
  wire logic [DLY_W-1:0] on_vec [NUM_OUT];
  wire logic [DLY_W-1:0] off_vec [NUM_OUT];

  assign src_vec[IDX_OC] = func_pick(oc_function_select_reg, func_src, drive_running); // [RQ7]
  assign src_vec[IDX_SECOND] = func_pick(second_function_select_reg, func_src,
                                         drive_running);
  assign src_vec[IDX_RELAY] = func_pick(relay_function_select_reg, func_src,
                                        drive_running); // [RQ10]
  assign on_vec[IDX_OC] = oc_output_on_delay_reg;
  assign off_vec[IDX_OC] = oc_output_off_delay_reg;
  assign on_vec[IDX_SECOND] = second_output_on_delay_reg;
  assign off_vec[IDX_SECOND] = second_output_off_delay_reg;
  assign on_vec[IDX_RELAY] = relay_on_delay_reg;
  assign off_vec[IDX_RELAY] = relay_off_delay_reg;

  odr_tick_div #(
    .TICK_LEN(TICK_LEN)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // one delay stage per output, each with its own pair of delays [RQ5]
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_dly
      odr_delay_line u_dly (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .src(src_vec[gi]),
        .on_dly(on_vec[gi]),
        .off_dly(off_vec[gi]),
        .out(dly_out[gi])
      );
    end
  endgenerate

  // coil level and polarity, polarity picked up on a signal edge
  wire logic relay_edge = (dly_out[IDX_RELAY] != (coil_reg ^ pol_active_reg[0]));
  wire logic coil_next = (relay_edge ? relay_coil_polarity_reg[0] : pol_active_reg[0])
                         ^ dly_out[IDX_RELAY];

  // status word
  wire logic [31:0] status_word = {24'h000000, drive_running, coil_reg,
                                   dly_out[IDX_RELAY], dly_out[IDX_SECOND], dly_out[IDX_OC],
                                   src_vec[IDX_RELAY], src_vec[IDX_SECOND], src_vec[IDX_OC]};

  wire logic [31:0] rd_mux =
    hit_pol ? {30'h00000000, relay_coil_polarity_reg} :
    hit_rfunc ? {26'h0000000, relay_function_select_reg} :
    hit_ofunc ? {26'h0000000, oc_function_select_reg} :
    hit_sfunc ? {26'h0000000, second_function_select_reg} :
    hit_oon ? {22'h000000, oc_output_on_delay_reg} :
    hit_ooff ? {22'h000000, oc_output_off_delay_reg} :
    hit_son ? {22'h000000, second_output_on_delay_reg} :
    hit_soff ? {22'h000000, second_output_off_delay_reg} :
    hit_ron ? {22'h000000, relay_on_delay_reg} :
    hit_roff ? {22'h000000, relay_off_delay_reg} :
    hit_stat ? status_word : 32'h00000000;

  // read data and error captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_reg <= !hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_coil_polarity_reg <= RELAY_POL_RESET; // [RQ9]
      relay_function_select_reg <= RELAY_FUNC_RESET; // [RQ9]
      oc_function_select_reg <= OC_FUNC_RESET;
      second_function_select_reg <= SECOND_FUNC_RESET;
    end else if (wr_en) begin
      if (hit_pol) begin
        relay_coil_polarity_reg <= pwdata[POL_W-1:0];
      end
      if (hit_rfunc) begin
        relay_function_select_reg <= pwdata[FUNC_W-1:0]; // [RQ10]
      end
      if (hit_ofunc) begin
        oc_function_select_reg <= pwdata[FUNC_W-1:0];
      end
      if (hit_sfunc) begin
        second_function_select_reg <= pwdata[FUNC_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_output_on_delay_reg <= DLY_RESET; // [RQ6]
      oc_output_off_delay_reg <= DLY_RESET;
      second_output_on_delay_reg <= DLY_RESET;
      second_output_off_delay_reg <= DLY_RESET;
      relay_on_delay_reg <= DLY_RESET;
      relay_off_delay_reg <= DLY_RESET;
    end else if (wr_en) begin
      if (hit_oon) begin
        oc_output_on_delay_reg <= dly_clamp(pwdata);
      end
      if (hit_ooff) begin
        oc_output_off_delay_reg <= dly_clamp(pwdata);
      end
      if (hit_son) begin
        second_output_on_delay_reg <= dly_clamp(pwdata);
      end
      if (hit_soff) begin
        second_output_off_delay_reg <= dly_clamp(pwdata);
      end
      if (hit_ron) begin
        relay_on_delay_reg <= dly_clamp(pwdata);
      end
      if (hit_roff) begin
        relay_off_delay_reg <= dly_clamp(pwdata);
      end
    end
  end

  // pin stage: coil and open-collector enables from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_active_reg <= RELAY_POL_RESET;
      coil_reg <= RELAY_POL_RESET[0];
      oc_oe_n_reg <= 1'b1;
      second_oe_n_reg <= 1'b1;
    end else begin
      if (relay_edge) begin
        pol_active_reg <= relay_coil_polarity_reg; // [RQ14]
      end
      coil_reg <= coil_next; // [RQ8]
      oc_oe_n_reg <= !dly_out[IDX_OC]; // [RQ12]
      second_oe_n_reg <= !dly_out[IDX_SECOND];
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = pslverr_reg && psel && penable;
  assign oc_pin_o = 1'b0; // [RQ12]
  assign oc_pin_oe_n = oc_oe_n_reg;
  assign second_pin_o = 1'b0;
  assign second_pin_oe_n = second_oe_n_reg;
  assign relay_coil = coil_reg;
endmodule
`default_nettype wire

// >>> inc/odr_pkg.sv
package odr_pkg;
  // controller clock and the delay tick
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_CNT_W = 23;

  // delay settings are held in tenths of a second
  localparam int unsigned DLY_W = 10;
  localparam logic [DLY_W-1:0] DLY_MAX = 10'h3E8;
  localparam logic [DLY_W-1:0] DLY_RESET = 10'h000;

  // output function codes
  localparam int unsigned FUNC_W = 6;
  localparam int unsigned FUNC_NUM = 64;
  localparam logic [FUNC_W-1:0] FUNC_RUN = 6'h00;
  localparam logic [FUNC_W-1:0] FUNC_ALARM = 6'h05;

  // relay coil polarity
  localparam int unsigned POL_W = 2;
  localparam logic [POL_W-1:0] POL_NORM_OPEN = 2'h0;
  localparam logic [POL_W-1:0] POL_NORM_CLOSED = 2'h1;

  // reset values of the selectors
  localparam logic [FUNC_W-1:0] RELAY_FUNC_RESET = FUNC_ALARM;
  localparam logic [POL_W-1:0] RELAY_POL_RESET = POL_NORM_CLOSED;
  localparam logic [FUNC_W-1:0] OC_FUNC_RESET = FUNC_RUN;
  localparam logic [FUNC_W-1:0] SECOND_FUNC_RESET = FUNC_RUN;

  // apb register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_RELAY_POL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RELAY_FUNC = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OC_FUNC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SECOND_FUNC = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_OC_ON = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OC_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SECOND_ON = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SECOND_OFF = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_RELAY_ON = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_RELAY_OFF = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;

  // status register field positions
  localparam int unsigned ST_OC_SRC = 0;
  localparam int unsigned ST_SECOND_SRC = 1;
  localparam int unsigned ST_RELAY_SRC = 2;
  localparam int unsigned ST_OC_OUT = 3;
  localparam int unsigned ST_SECOND_OUT = 4;
  localparam int unsigned ST_RELAY_OUT = 5;
  localparam int unsigned ST_COIL = 6;
  localparam int unsigned ST_RUN = 7;

  // number of delayed outputs: open collector, second, relay
  localparam int unsigned NUM_OUT = 3;
  localparam int unsigned IDX_OC = 0;
  localparam int unsigned IDX_SECOND = 1;
  localparam int unsigned IDX_RELAY = 2;
endpackage

// >>> src/odr_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module odr_tick_div
  import odr_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  logic [TICK_CNT_W-1:0] cnt_reg;
  wire logic cnt_end = (cnt_reg == TICK_CNT_W'(TICK_LEN - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (cnt_end) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick = cnt_end;
endmodule
`default_nettype wire

// >>> src/odr_delay_line.sv
`timescale 1ns/1ps
`default_nettype none
module odr_delay_line
  import odr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic src,
  input wire logic [DLY_W-1:0] on_dly,
  input wire logic [DLY_W-1:0] off_dly,
  output logic out
);
  logic out_reg;
  logic busy_reg;
  logic [DLY_W-1:0] cnt_reg;
  logic [DLY_W-1:0] lim_reg;

  // delay for the pending edge, sampled when the edge starts
  wire logic [DLY_W-1:0] edge_dly = src ? on_dly : off_dly;
  wire logic differ = (src != out_reg);
  wire logic [DLY_W-1:0] lim = busy_reg ? lim_reg : edge_dly;
  wire logic expire = differ && ((lim == '0) || (tick && (cnt_reg + 1'b1 >= lim)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 1'b0;
      busy_reg <= 1'b0;
      cnt_reg <= '0;
      lim_reg <= DLY_RESET;
    end else if (!differ) begin
      // source went back before expiry: restart from zero [RQ13]
      busy_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (expire) begin
      out_reg <= src; // [RQ1] [RQ2] [RQ3] [RQ6]
      busy_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      busy_reg <= 1'b1;
      if (!busy_reg) begin
        lim_reg <= edge_dly; // [RQ14]
      end
      if (tick) begin
        cnt_reg <= cnt_reg + 1'b1; // [RQ13]
      end
    end
  end

  assign out = out_reg;
endmodule
`default_nettype wire

// >>> verification/odr_out_cond_properties.sv
`timescale 1ns/1ps
`default_nettype none
module odr_out_cond_properties
  import odr_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [FUNC_NUM-1:0] func_src,
  input wire logic drive_running,
  input wire logic oc_pin_o,
  input wire logic oc_pin_oe_n,
  input wire logic second_pin_o,
  input wire logic second_pin_oe_n,
  input wire logic relay_coil
);
  logic [FUNC_W-1:0] oc_fn_reg;
  logic [DLY_W-1:0] oc_on_reg, oc_off_reg, wr_dly;
  logic [7:0] quiet_reg;
  logic [15:0] hi_reg, lo_reg;
  logic wr, oc_src, settled;
  assign wr = psel && penable && pwrite;
  assign wr_dly = (pwdata > 32'h3E8) ? DLY_MAX : pwdata[DLY_W-1:0];
  assign oc_src = (oc_fn_reg == FUNC_RUN) ? drive_running : func_src[oc_fn_reg];
  assign settled = (quiet_reg == 8'hFF);
  // shadow of the open-collector settings and run lengths of its source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_fn_reg <= OC_FUNC_RESET;
      oc_on_reg <= DLY_RESET;
      oc_off_reg <= DLY_RESET;
      quiet_reg <= 8'h00;
      hi_reg <= 16'h0000;
      lo_reg <= 16'h0000;
    end else begin
      if (wr && paddr == OFS_OC_FUNC) oc_fn_reg <= pwdata[FUNC_W-1:0];
      if (wr && paddr == OFS_OC_ON) oc_on_reg <= wr_dly;
      if (wr && paddr == OFS_OC_OFF) oc_off_reg <= wr_dly;
      quiet_reg <= wr ? 8'h00 : (settled ? quiet_reg : quiet_reg + 8'h01);
      hi_reg <= !oc_src ? 16'h0000 : (&hi_reg ? hi_reg : hi_reg + 16'h0001);
      lo_reg <= oc_src ? 16'h0000 : (&lo_reg ? lo_reg : lo_reg + 16'h0001);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_s;
    psel && penable;
  endsequence
  chk_ready_high: assert property (access_s |-> pready)
    else $error("pready low in access phase");
  chk_pins_no_drive: assert property (!oc_pin_o && !second_pin_o)
    else $error("open-collector pin driven high");
  chk_err_unmapped: assert property (access_s ##0 paddr > OFS_STATUS |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (access_s ##0 paddr <= OFS_STATUS && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("error on mapped access");
  chk_read_unmapped: assert property (access_s ##0 !pwrite && paddr > OFS_STATUS
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  chk_coil_reset: assert property ($rose(presetn) |-> relay_coil)
    else $error("coil not energized after reset");
  chk_oc_zero_dly: assert property (oc_on_reg == 0 && oc_off_reg == 0 && settled
    |-> oc_pin_oe_n == !$past(oc_src, 2)) else $error("undelayed pin wrong");
  chk_on_filter: assert property ($fell(oc_pin_oe_n) && oc_on_reg != 0 && settled
    |-> $past(hi_reg) >= (oc_on_reg - 1) * TICK_LEN) else $error("on edge too early");
  chk_off_filter: assert property ($rose(oc_pin_oe_n) && oc_off_reg != 0 && settled
    |-> $past(lo_reg) >= (oc_off_reg - 1) * TICK_LEN) else $error("off edge too early");
endmodule
bind odr_out_cond odr_out_cond_properties #(.TICK_LEN(TICK_LEN)) u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .func_src(func_src),
  .drive_running(drive_running),
  .oc_pin_o(oc_pin_o),
  .oc_pin_oe_n(oc_pin_oe_n),
  .second_pin_o(second_pin_o),
  .second_pin_oe_n(second_pin_oe_n),
  .relay_coil(relay_coil)
);
`default_nettype wire

// >>> verification/odr_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module odr_field_model (
  input wire logic oc_pin_o,
  input wire logic oc_pin_oe_n,
  input wire logic second_pin_o,
  input wire logic second_pin_oe_n,
  input wire logic relay_coil,
  output logic oc_line,
  output logic second_line,
  output logic relay_make_contact,
  output logic relay_break_contact
);
  // pull-up on the lines while the transistor is off
  assign oc_line = oc_pin_oe_n ? 1'b1 : oc_pin_o;
  assign second_line = second_pin_oe_n ? 1'b1 : second_pin_o;
  assign relay_make_contact = relay_coil;
  assign relay_break_contact = !relay_coil;
endmodule
`default_nettype wire

// >>> verification/odr_out_cond_tb.sv
`timescale 1ns/1ps
`default_nettype none
module odr_out_cond_tb;
  import odr_pkg::*;
  localparam int unsigned TL = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, drive_running;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [FUNC_NUM-1:0] func_src;
  logic oc_pin_o, oc_pin_oe_n, second_pin_o, second_pin_oe_n, relay_coil, oc_prev;
  logic oc_line, second_line, relay_make_contact, relay_break_contact;
  int n_mismatch = 0;
  int num_checks = 0;
  int oc_edges = 0;
  int e;
  odr_out_cond #(.TICK_LEN(TL)) uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .func_src(func_src),
    .drive_running(drive_running),
    .oc_pin_o(oc_pin_o),
    .oc_pin_oe_n(oc_pin_oe_n),
    .second_pin_o(second_pin_o),
    .second_pin_oe_n(second_pin_oe_n),
    .relay_coil(relay_coil)
  );
  odr_field_model u_field (
    .oc_pin_o(oc_pin_o),
    .oc_pin_oe_n(oc_pin_oe_n),
    .second_pin_o(second_pin_o),
    .second_pin_oe_n(second_pin_oe_n),
    .relay_coil(relay_coil),
    .oc_line(oc_line),
    .second_line(second_line),
    .relay_make_contact(relay_make_contact),
    .relay_break_contact(relay_break_contact)
  );
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (oc_line !== oc_prev) oc_edges++;
    oc_prev <= oc_line;
  end
  task automatic conclude();
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(err, eerr);
  endtask
  initial begin
    presetn <= 1'b0;
    {psel, penable, pwrite, drive_running} <= 4'h0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    func_src <= '0;
    wt(2);
    presetn <= 1'b1;
    chk(relay_coil, 32'h1);
    rchk(OFS_RELAY_POL, 32'h1, 1'b0);
    rchk(OFS_RELAY_FUNC, 32'h5, 1'b0);
    for (int i = 2; i < 10; i++) rchk(ADDR_W'(i * 4), 32'h0, 1'b0);
    rchk(8'h2C, 32'h0, 1'b1);
    apb(1'b1, OFS_RELAY_OFF, 32'h7D0);
    rchk(OFS_RELAY_OFF, 32'h3E8, 1'b0);
    apb(1'b1, OFS_RELAY_OFF, 32'h0);
    wt(260);
    drive_running <= 1'b1;
    wt(3);
    chk({oc_line, second_line}, 32'h0);
    drive_running <= 1'b0;
    func_src[FUNC_ALARM] <= 1'b1;
    wt(3);
    chk({oc_line, second_line, relay_make_contact, relay_break_contact}, 32'hD);
    apb(1'b1, OFS_RELAY_POL, 32'h0);
    func_src[FUNC_ALARM] <= 1'b0;
    wt(3);
    chk(relay_coil, 32'h0);
    apb(1'b1, OFS_RELAY_FUNC, 32'h9);
    apb(1'b1, OFS_OC_FUNC, 32'h5);
    apb(1'b1, OFS_OC_ON, 32'h3);
    wt(260);
    func_src[9] <= 1'b1;
    wt(3);
    chk(relay_coil, 32'h1);
    e = oc_edges;
    func_src[5] <= 1'b1;
    wt(15);
    func_src[5] <= 1'b0;
    wt(40);
    chk(oc_edges, e);
    func_src[5] <= 1'b1;
    wt(15);
    chk(oc_line, 32'h1);
    wt(20);
    chk(oc_line, 32'h0);
    func_src[5] <= 1'b0;
    wt(3);
    chk(oc_line, 32'h1);
    apb(1'b1, OFS_OC_OFF, 32'h3);
    wt(260);
    func_src[5] <= 1'b1;
    wt(35);
    e = oc_edges;
    func_src[5] <= 1'b0;
    wt(15);
    func_src[5] <= 1'b1;
    wt(40);
    chk(oc_edges, e);
    func_src[5] <= 1'b0;
    wt(15);
    chk(oc_line, 32'h0);
    wt(20);
    chk(oc_line, 32'h1);
    drive_running <= 1'b1;
    wt(3);
    chk(second_line, 32'h0);
    drive_running <= 1'b0;
    wt(3);
    chk(second_line, 32'h1);
    rchk(OFS_STATUS, 32'h64, 1'b0);
    conclude();
  end
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
